// [rcc_reset_clock.sv]
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rcc_regs.svh"
// Function
// [RULE1] Bit 0 of the origin flags records a reset from the external active-low pin.
// [RULE2] Bit 1 records a power-on reset.
// [RULE3] Bit 2 records a brown-out reset.
// [RULE4] Bit 3 records a watchdog reset.
// [RULE5] Bit 4 records a software-requested reset.
// [RULE6] Bit 5 records loss of regulator power-good; bits 31 to 6 are reserved.
// [RULE7] A pin reset clears the other flags, any other cause adds to those already set.
// [RULE8] The flags are read-write, so software may clear or set them.
// [RULE9] With auto gating set, sleep and deep sleep use their own gating sets, else run's.
// [RULE10] In run mode the peripheral enables always come from the run gating set.
// [RULE11] The divisor field resets to 0xf, code n divides by n+1, codes below 1001 reserved.
// [RULE12] Divider select, reset 0, applies the divider; the divider is forced while on PLL.
// [RULE13] Power-down drives the PLL power-down, it and output gate reset to 1.
// [RULE14] The PLL clock leaves the PLL only while the output gate bit is clear.
// [RULE15] Bypass set takes the oscillator, clear takes the PLL output divided.
module rcc_reset_clock import rcc_pkg::*; #(
    parameter int NUM_PERIPH = 8
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // axi4-lite write
    input wire logic [`RCC_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read
    input wire logic [`RCC_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // reset origin pins
    input wire logic PIN_RESET_CAUSE_N,
    input wire logic POWER_ON_CAUSE,
    input wire logic BROWNOUT_CAUSE,
    input wire logic WATCHDOG_CAUSE,
    input wire logic SOFTWARE_RESET_CAUSE,
    input wire logic REGULATOR_LOSS_CAUSE,
    // clock sources
    input wire logic RAW_CLOCK_SOURCE,
    input wire logic PLL_CLOCK,
    // peripheral gating
    input wire logic [1:0] POWER_MODE,
    input wire logic [NUM_PERIPH-1:0] RUN_GATING_REGS,
    input wire logic [NUM_PERIPH-1:0] SLEEP_GATING_REGS,
    input wire logic [NUM_PERIPH-1:0] DEEP_SLEEP_GATING_REGS,
    // clock control and interrupt outputs
    output logic PLL_POWER_DOWN,
    output logic PLL_OUTPUT_GATE_N,
    output logic SYS_CLK_EN,
    output logic [NUM_PERIPH-1:0] PERIPH_CLK_EN,
    output logic IRQ
);
    localparam int NSYNC = `RCC_NCAUSE + 2;

    logic [NSYNC-1:0] raw_in, sync1_reg, sync2_reg, sync3_reg, rise;
    logic [`RCC_NCAUSE-1:0] cause_evt, cause_reg, irq_stat_reg, irq_mask_reg;
    logic [31:0] setup_reg, cur_word, wmerge, wbytes, rd_word;
    logic [`RCC_ADDR_W-1:0] aw_addr_reg, wr_addr, rd_addr;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_held_reg, w_held_reg, awready_reg, wready_reg, bvalid_reg;
    logic arready_reg, rvalid_reg, irq_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic do_aw, do_w, do_ar, wr_fire, wr_hit, rd_hit;
    logic wr_cause, wr_setup, wr_stat, wr_mask;
    logic auto_gating, divider_select, pll_power_down, pll_output_gate_n, bypass;
    logic [`RCC_DIV_W-1:0] clock_divisor, eff_div;
    logic pll_on, osc_tick, pll_tick, src_tick, divide_on;
    logic [NUM_PERIPH-1:0] periph_en_reg;
    rcc_mode_type mode;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; the second and third stages feed edge detection
    assign raw_in = {PLL_CLOCK, RAW_CLOCK_SOURCE, REGULATOR_LOSS_CAUSE, SOFTWARE_RESET_CAUSE,
                     WATCHDOG_CAUSE, BROWNOUT_CAUSE, POWER_ON_CAUSE, ~PIN_RESET_CAUSE_N};

    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            always_ff @(posedge CLK or posedge RESET) begin
                if (RESET) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                    sync3_reg[i] <= 1'b0;
                end else begin
                    sync1_reg[i] <= raw_in[i];
                    sync2_reg[i] <= sync1_reg[i];
                    sync3_reg[i] <= sync2_reg[i];
                end
            end
            assign rise[i] = sync2_reg[i] & ~sync3_reg[i];
        end
    endgenerate

    assign cause_evt = rise[`RCC_NCAUSE-1:0];
    assign osc_tick = rise[`RCC_NCAUSE];

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write path
    assign do_aw = S_AXI_AWVALID & awready_reg;
    assign do_w = S_AXI_WVALID & wready_reg;
    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_addr = {aw_addr_reg[`RCC_ADDR_W-1:2], 2'b00};

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else begin
            if (do_aw) begin
                aw_addr_reg <= S_AXI_AWADDR;
            end
            aw_held_reg <= (aw_held_reg | do_aw) & ~wr_fire;
            awready_reg <= ~((aw_held_reg | do_aw) & ~wr_fire);
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            if (do_w) begin
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end
            w_held_reg <= (w_held_reg | do_w) & ~wr_fire;
            wready_reg <= ~((w_held_reg | do_w) & ~wr_fire);
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `RCC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? `RCC_RESP_OKAY : `RCC_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign wr_cause = wr_fire && wr_addr == `RCC_CAUSE_OFS;
    assign wr_setup = wr_fire && wr_addr == `RCC_SETUP_OFS;
    assign wr_stat = wr_fire && wr_addr == `RCC_IRQ_STAT_OFS;
    assign wr_mask = wr_fire && wr_addr == `RCC_IRQ_MASK_OFS;
    assign wr_hit = wr_cause | wr_setup | wr_stat | wr_mask;

    always_comb begin
        unique case (wr_addr)
            `RCC_CAUSE_OFS: cur_word = {{(32-`RCC_NCAUSE){1'b0}}, cause_reg};
            `RCC_SETUP_OFS: cur_word = setup_reg;
            `RCC_IRQ_STAT_OFS: cur_word = {{(32-`RCC_NCAUSE){1'b0}}, irq_stat_reg};
            `RCC_IRQ_MASK_OFS: cur_word = {{(32-`RCC_NCAUSE){1'b0}}, irq_mask_reg};
            default: cur_word = '0;
        endcase
    end

    // byte lanes without a strobe keep their old contents
    generate
        for (genvar b = 0; b < 4; b++) begin : g_lane
            assign wmerge[8*b +: 8] = wstrb_reg[b] ? wdata_reg[8*b +: 8] : cur_word[8*b +: 8];
            assign wbytes[8*b +: 8] = wstrb_reg[b] ? wdata_reg[8*b +: 8] : 8'h00;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read path
    assign do_ar = S_AXI_ARVALID & arready_reg;
    assign rd_addr = {S_AXI_ARADDR[`RCC_ADDR_W-1:2], 2'b00};

    always_comb begin
        rd_hit = 1'b1;
        unique case (rd_addr)
            `RCC_CAUSE_OFS: rd_word = {{(32-`RCC_NCAUSE){1'b0}}, cause_reg}; // see [RULE6]
            `RCC_SETUP_OFS: rd_word = setup_reg;
            `RCC_IRQ_STAT_OFS: rd_word = {{(32-`RCC_NCAUSE){1'b0}}, irq_stat_reg};
            `RCC_IRQ_MASK_OFS: rd_word = {{(32-`RCC_NCAUSE){1'b0}}, irq_mask_reg};
            default: begin
                rd_word = '0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= `RCC_RESP_OKAY;
        end else begin
            if (do_ar) begin
                rdata_reg <= rd_word;
                rresp_reg <= rd_hit ? `RCC_RESP_OKAY : `RCC_RESP_SLVERR;
            end
            rvalid_reg <= do_ar | (rvalid_reg & ~S_AXI_RREADY);
            arready_reg <= ~(do_ar | (rvalid_reg & ~S_AXI_RREADY));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset origin flags; a cause arriving with a write wins
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cause_reg <= `RCC_CAUSE_RESET;
        end else if (cause_evt[`RCC_PIN_BIT]) begin
            cause_reg <= cause_evt; // see [RULE1] see [RULE7]
        end else if (|cause_evt) begin
            cause_reg <= cause_reg | cause_evt; // see [RULE2] see [RULE3] see [RULE4] see [RULE5] see [RULE6] see [RULE7]
        end else if (wr_cause) begin
            cause_reg <= wmerge[`RCC_NCAUSE-1:0]; // see [RULE8]
        end
    end

    // each cause also raises a sticky interrupt flag, cleared by writing one
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? wbytes[`RCC_NCAUSE-1:0] : '0))
                            | cause_evt;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            irq_mask_reg <= '0;
        end else if (wr_mask) begin
            irq_mask_reg <= wmerge[`RCC_NCAUSE-1:0];
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run clock setup
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            setup_reg <= `RCC_SETUP_RESET; // see [RULE11] see [RULE13]
        end else if (wr_setup) begin
            setup_reg <= (setup_reg & ~`RCC_SETUP_WMASK) | (wmerge & `RCC_SETUP_WMASK);
        end
    end

    assign auto_gating = setup_reg[`RCC_AUTO_GATE_BIT];
    assign clock_divisor = setup_reg[`RCC_DIV_HI:`RCC_DIV_LO];
    assign divider_select = setup_reg[`RCC_DIV_SEL_BIT];
    assign pll_power_down = setup_reg[`RCC_PLL_POWER_DOWN_BIT];
    assign pll_output_gate_n = setup_reg[`RCC_OEN_BIT];
    assign bypass = setup_reg[`RCC_BYPASS_BIT];

    // reserved divisor codes fall back to the slowest rate, never overclock
    assign eff_div = (clock_divisor < `RCC_DIV_MIN) ? `RCC_DIV_FALLBACK : clock_divisor; // see [RULE11]
    assign pll_on = ~pll_power_down & ~pll_output_gate_n; // see [RULE13]
    assign pll_tick = rise[`RCC_NCAUSE+1] & pll_on; // see [RULE14]
    assign src_tick = bypass ? osc_tick : pll_tick; // see [RULE15]
    assign divide_on = divider_select | ~bypass; // see [RULE12]

    rcc_clkdiv u_div (
        .clk(CLK),
        .reset(RESET),
        .src_tick(src_tick),
        .divide_on(divide_on),
        .div_code(eff_div),
        .tick(SYS_CLK_EN)
    );

    ////////////////////////////////////////////////////////////////////////////
    // peripheral clock gating
    assign mode = rcc_mode_type'(POWER_MODE);

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            periph_en_reg <= '0;
        end else begin
            unique case (mode)
                RCC_RUN: periph_en_reg <= RUN_GATING_REGS; // see [RULE10]
                RCC_SLEEP: periph_en_reg <= auto_gating ? SLEEP_GATING_REGS
                                                        : RUN_GATING_REGS; // see [RULE9]
                RCC_DEEP: periph_en_reg <= auto_gating ? DEEP_SLEEP_GATING_REGS
                                                       : RUN_GATING_REGS; // see [RULE9]
                default: periph_en_reg <= RUN_GATING_REGS;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RDATA = rdata_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign PLL_POWER_DOWN = pll_power_down; // see [RULE13]
    assign PLL_OUTPUT_GATE_N = pll_output_gate_n; // see [RULE14]
    assign PERIPH_CLK_EN = periph_en_reg;
    assign IRQ = irq_reg;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    pin_clears_others_a: assert property (cause_evt[`RCC_PIN_BIT] |=> // see [RULE1]
        cause_reg == $past(cause_evt))
        else $error("pin reset did not clear other flags");
    causes_accumulate_a: assert property ( // see [RULE7]
        (|cause_evt && !cause_evt[`RCC_PIN_BIT]) |=>
        cause_reg == ($past(cause_reg) | $past(cause_evt)))
        else $error("non-pin cause did not accumulate");
    cause_write_a: assert property ((wr_cause && !(|cause_evt)) |=> // see [RULE8]
        cause_reg == $past(wmerge[`RCC_NCAUSE-1:0]))
        else $error("origin flag write lost");
    run_gating_a: assert property (mode == RCC_RUN |=> // see [RULE10]
        PERIPH_CLK_EN == $past(RUN_GATING_REGS))
        else $error("run mode not using run gating");
    sleep_gating_a: assert property ((mode == RCC_SLEEP && auto_gating) |=> // see [RULE9]
        PERIPH_CLK_EN == $past(SLEEP_GATING_REGS))
        else $error("sleep mode not using sleep gating");
    pll_gate_a: assert property ((pll_power_down || pll_output_gate_n) |-> // see [RULE14]
        !pll_tick)
        else $error("pll clock escaped while gated");
    div_forced_a: assert property (!bypass |-> divide_on) // see [RULE12]
        else $error("divider not forced on pll source");
    div_legal_a: assert property (eff_div >= `RCC_DIV_MIN) // see [RULE11]
        else $error("reserved divisor in use");
    bypass_pass_a: assert property ((!divide_on && src_tick) |=> SYS_CLK_EN) // see [RULE15]
        else $error("undivided source tick missing");
    no_src_a: assert property (!src_tick |=> !SYS_CLK_EN) // see [RULE15]
        else $error("system enable without source tick");
    irq_level_a: assert property ((|(irq_stat_reg & irq_mask_reg)) |=> IRQ)
        else $error("interrupt not raised");

    pin_reset_c: cover property (cause_evt[`RCC_PIN_BIT]);
    two_causes_c: cover property (cause_reg[`RCC_POR_BIT] && cause_reg[`RCC_WATCHDOG_BIT]);
    pll_clock_c: cover property (!bypass && SYS_CLK_EN);
    deep_auto_c: cover property (mode == RCC_DEEP && auto_gating);
endmodule : rcc_reset_clock

// [rcc_regs.svh]
`ifndef RCC_REGS_SVH
`define RCC_REGS_SVH
// register byte offsets
`define RCC_ADDR_W 12
`define RCC_CAUSE_OFS 12'h05c
`define RCC_SETUP_OFS 12'h060
`define RCC_IRQ_STAT_OFS 12'h070
`define RCC_IRQ_MASK_OFS 12'h074
// reset origin flags
`define RCC_NCAUSE 6
`define RCC_PIN_BIT 0
`define RCC_POR_BIT 1
`define RCC_BROWNOUT_BIT 2
`define RCC_WATCHDOG_BIT 3
`define RCC_SOFTWARE_BIT 4
`define RCC_REGULATOR_BIT 5
`define RCC_CAUSE_RESET 6'h00
`define RCC_OTHER_HI 5
`define RCC_OTHER_LO 1
// run clock setup fields
`define RCC_AUTO_GATE_BIT 27
`define RCC_DIV_HI 26
`define RCC_DIV_LO 23
`define RCC_DIV_SEL_BIT 22
`define RCC_PLL_POWER_DOWN_BIT 13
`define RCC_OEN_BIT 12
`define RCC_BYPASS_BIT 11
`define RCC_SETUP_RESET 32'h07bf_fac0
`define RCC_SETUP_WMASK 32'h0fc0_3ffc
`define RCC_DIV_W 4
`define RCC_DIV_MIN 4'h9
`define RCC_DIV_FALLBACK 4'hf
// bus answers
`define RCC_RESP_OKAY 2'b00
`define RCC_RESP_SLVERR 2'b10
`endif

// [rcc_pkg.sv]
package rcc_pkg;
    typedef enum logic [1:0] {RCC_RUN, RCC_SLEEP, RCC_DEEP} rcc_mode_type;
endpackage : rcc_pkg

// [rcc_clkdiv.sv]
`timescale 1ns/1ps
`include "rcc_regs.svh"
module rcc_clkdiv (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // source and setting
    input wire logic src_tick,
    input wire logic divide_on,
    input wire logic [`RCC_DIV_W-1:0] div_code,
    // divided enable
    output logic tick
);
    logic [`RCC_DIV_W-1:0] cnt_reg;
    logic tick_reg;

    ////////////////////////////////////////////////////////////////////////////
    // code n gives one pulse per n+1 source ticks
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
        end else if (!divide_on) begin
            cnt_reg <= '0;
        end else if (src_tick) begin
            cnt_reg <= (cnt_reg >= div_code) ? '0 : cnt_reg + 1'b1; // see [RULE11]
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= src_tick && (!divide_on || cnt_reg >= div_code); // see [RULE12]
        end
    end

    assign tick = tick_reg;

    ////////////////////////////////////////////////////////////////////////////
    div_hold_a: assert property (@(posedge clk) disable iff (reset) // see [RULE11]
        (divide_on && src_tick && cnt_reg < div_code) |=> !tick_reg)
        else $error("divided enable fired before the count ended");
    div_fire_a: assert property (@(posedge clk) disable iff (reset) // see [RULE11]
        (divide_on && src_tick && cnt_reg == div_code) |=> tick_reg && cnt_reg == '0)
        else $error("divided enable missing at end of count");
endmodule : rcc_clkdiv

// [rcc_reset_clock_bench.sv]
`timescale 1ns/1ps
`include "rcc_regs.svh"
module rcc_reset_clock_bench import rcc_pkg::*; ;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, pll_pd, pll_gate_n, sys_en, irq;
    logic [1:0] bresp, rresp;
    logic [1:0] power_mode = 2'h0;
    logic [5:0] ev = 6'h00;
    logic raw_src = 0, pll_src = 0;
    logic [7:0] run_g = 8'h00, sleep_g = 8'h00, deep_g = 8'h00, periph_en;
    int error_cnt = 0;
    int tests_run = 0;
    int pulses = 0;
    logic [31:0] d;
    logic [1:0] r;

    always #2 clk = ~clk;
    always @(posedge clk) if (sys_en === 1'b1) pulses <= pulses + 1;

    rcc_reset_clock #(.NUM_PERIPH(8)) uut (.CLK(clk), .RESET(reset),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .PIN_RESET_CAUSE_N(~ev[0]), .POWER_ON_CAUSE(ev[1]), .BROWNOUT_CAUSE(ev[2]),
        .WATCHDOG_CAUSE(ev[3]), .SOFTWARE_RESET_CAUSE(ev[4]),
        .REGULATOR_LOSS_CAUSE(ev[5]), .RAW_CLOCK_SOURCE(raw_src), .PLL_CLOCK(pll_src),
        .POWER_MODE(power_mode), .RUN_GATING_REGS(run_g), .SLEEP_GATING_REGS(sleep_g),
        .DEEP_SLEEP_GATING_REGS(deep_g), .PLL_POWER_DOWN(pll_pd),
        .PLL_OUTPUT_GATE_N(pll_gate_n), .SYS_CLK_EN(sys_en), .PERIPH_CLK_EN(periph_en),
        .IRQ(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check32

    // divider phase at a setting change is unknown, hence the slack
    task automatic check_cnt(input string what, input int exp, input int got, input int tol);
        tests_run++;
        if (got < exp - tol || got > exp + tol) begin
            error_cnt++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_cnt

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    ////////////////////////////////////////////////////////////////////////////////
    // waits are ended only by the watchdog; one idle edge after each answer
    task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs,
                             input logic [3:0] s = 4'hf);
        bit aw_done, w_done, aw_hit, w_hit, b_hit;
        aw_done = 0;
        w_done = 0;
        b_hit = 0;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge clk);
            aw_hit = !aw_done && awready === 1'b1;
            w_hit = !w_done && wready === 1'b1;
            @(posedge clk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            aw_done = aw_done | aw_hit;
            w_done = w_done | w_hit;
        end
        while (!b_hit) begin
            @(negedge clk);
            b_hit = bvalid === 1'b1;
            rs = bresp;
            @(posedge clk);
        end
        bready <= 1'b0;
        @(posedge clk);
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        bit hit;
        hit = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!hit) begin
            @(negedge clk);
            hit = arready === 1'b1;
            @(posedge clk);
        end
        arvalid <= 1'b0;
        hit = 0;
        while (!hit) begin
            @(negedge clk);
            hit = rvalid === 1'b1;
            v = rdata;
            rs = rresp;
            @(posedge clk);
        end
        rready <= 1'b0;
        @(posedge clk);
    endtask : axi_read

    task automatic pulse_cause(input int b);
        ev[b] <= 1'b1;
        cyc(4);
        ev[b] <= 1'b0;
        cyc(6);
    endtask : pulse_cause

    function automatic logic [31:0] setup_word(input logic [3:0] dv, input logic sel, pd, oe, by);
        setup_word = {5'h00, dv, sel, 8'hff, pd, oe, by, 11'h2c0};
    endfunction : setup_word

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        @(negedge clk);
        check32("pll power down", 32'h1, pll_pd);
        check32("pll gate", 32'h1, pll_gate_n);
        @(posedge clk);
        axi_read(`RCC_SETUP_OFS, d, r);
        check32("setup div", 32'h1e, d[27:22]);
        check32("setup pll", 32'h7, d[13:11]);
        check32("setup resp", `RCC_RESP_OKAY, r);
        axi_read(`RCC_CAUSE_OFS, d, r);
        check32("cause reset", 32'h0, d);
    endtask : t_reset_values

    task automatic t_causes;
        logic [31:0] exp;
        exp = 32'h0;
        for (int b = 1; b < 6; b++) begin
            pulse_cause(b);
            axi_read(`RCC_CAUSE_OFS, d, r);
            exp[b] = 1'b1;
            check32("cause flags", exp, d);
        end
        pulse_cause(0);
        axi_read(`RCC_CAUSE_OFS, d, r);
        check32("pin cause", 32'h1, d);
    endtask : t_causes

    task automatic t_sw_write;
        logic [31:0] wv [3] = '{32'h3e, 32'h0, 32'hffff_ffff};
        logic [31:0] ex [3] = '{32'h3e, 32'h0, 32'h3f};
        for (int i = 0; i < 3; i++) begin
            axi_write(`RCC_CAUSE_OFS, wv[i], r);
            axi_read(`RCC_CAUSE_OFS, d, r);
            check32("cause write", ex[i], d);
        end
    endtask : t_sw_write

    task automatic t_irq;
        axi_write(`RCC_IRQ_STAT_OFS, 32'h3f, r);
        axi_write(`RCC_IRQ_MASK_OFS, 32'h0, r);
        pulse_cause(3);
        axi_read(`RCC_IRQ_STAT_OFS, d, r);
        check32("irq status", 32'h08, d);
        check32("irq masked", 32'h0, irq);
        axi_write(`RCC_IRQ_MASK_OFS, 32'h08, r);
        cyc(2);
        check32("irq raised", 32'h1, irq);
        axi_write(`RCC_IRQ_STAT_OFS, 32'h08, r);
        cyc(2);
        check32("irq cleared", 32'h0, irq);
        axi_read(`RCC_IRQ_STAT_OFS, d, r);
        check32("irq status clear", 32'h0, d);
    endtask : t_irq

    task automatic t_unmapped;
        axi_read(12'h200, d, r);
        check32("unmapped rdata", 32'h0, d);
        check32("unmapped rresp", `RCC_RESP_SLVERR, r);
        axi_write(12'h200, 32'h1, r);
        check32("unmapped bresp", `RCC_RESP_SLVERR, r);
    endtask : t_unmapped

    task automatic t_setup_rw;
        axi_write(`RCC_SETUP_OFS, 32'hffff_ffff, r);
        axi_read(`RCC_SETUP_OFS, d, r);
        check32("setup ones", 32'h0fff_fffc, d);
        axi_write(`RCC_SETUP_OFS, 32'h0, r);
        axi_read(`RCC_SETUP_OFS, d, r);
        check32("setup zeros", 32'h003f_c000, d);
        check32("pd cleared", 32'h0, pll_pd);
        check32("gate cleared", 32'h0, pll_gate_n);
        // only lane 1 strobed: bits 13:8 set, the rest keep their value
        axi_write(`RCC_SETUP_OFS, 32'hffff_ffff, r, 4'h2);
        axi_read(`RCC_SETUP_OFS, d, r);
        check32("setup lane", 32'h003f_ff00, d);
    endtask : t_setup_rw

    // each row: setting, source, ticks offered, pulses expected, slack
    task automatic t_clock;
        logic [31:0] cfg [6] = '{setup_word(4'hf, 0, 1, 1, 1), setup_word(4'h9, 1, 1, 1, 1),
            setup_word(4'h0, 1, 1, 1, 1), setup_word(4'h9, 0, 0, 0, 0),
            setup_word(4'h9, 0, 0, 1, 0), setup_word(4'hf, 0, 0, 0, 1)};
        bit on_pll [6] = '{0, 0, 0, 1, 1, 1};
        int nt [6] = '{32, 100, 64, 100, 40, 40};
        int ex [6] = '{32, 10, 4, 10, 0, 0};
        int tol [6] = '{0, 1, 1, 1, 0, 0};
        int p0;
        for (int i = 0; i < 6; i++) begin
            axi_write(`RCC_SETUP_OFS, cfg[i], r);
            cyc(10);
            p0 = pulses;
            repeat (nt[i]) begin
                if (on_pll[i]) pll_src <= 1'b1;
                else raw_src <= 1'b1;
                cyc(3);
                pll_src <= 1'b0;
                raw_src <= 1'b0;
                cyc(3);
            end
            cyc(10);
            p0 = pulses - p0;
            check_cnt("sys ticks", ex[i], p0, tol[i]);
            check32("pd pin", cfg[i][13], pll_pd);
        end
    endtask : t_clock

    task automatic t_gating;
        logic [7:0] exp;
        run_g <= 8'ha5;
        sleep_g <= 8'h3c;
        deep_g <= 8'hc3;
        for (int ag = 0; ag < 2; ag++) begin
            axi_write(`RCC_SETUP_OFS, setup_word(4'hf, 0, 1, 1, 1) | (ag << 27), r);
            for (int m = 0; m < 4; m++) begin
                power_mode <= m[1:0];
                cyc(3);
                exp = (ag == 1 && m == 1) ? 8'h3c : (ag == 1 && m == 2) ? 8'hc3 : 8'ha5;
                check32("periph enables", exp, periph_en);
            end
        end
    endtask : t_gating

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard, well past the few thousand cycles the run needs
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        $display("ERROR watchdog expired");
        results();
    end

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        cyc(2);
        t_reset_values();
        t_causes();
        t_sw_write();
        t_irq();
        t_unmapped();
        t_setup_rw();
        t_clock();
        t_gating();
        results();
    end
endmodule : rcc_reset_clock_bench
